// [sfcso_pkg.sv]
/*
  Shared constants for the safety command and status object bank:
  object indices, field positions, reset values, timing counts, states.
  Assumes a single 40 MHz clock domain for every user of the package.
*/
package sfcso_pkg;

  // Clock and millisecond tick timing
  localparam int CLK_HZ      = 40_000_000;
  localparam int TICK_MS     = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int TMR_W       = 17;

  // Object dictionary indices
  localparam logic [15:0] IDX_CMD_ECHO   = 16'h6620;
  localparam logic [15:0] IDX_STATUS     = 16'h6621;
  localparam logic [15:0] IDX_RESTART    = 16'h6630;
  localparam logic [15:0] IDX_FAULT      = 16'h6632;
  localparam logic [15:0] IDX_TORQUE_OFF = 16'h6640;
  localparam logic [15:0] IDX_OFF_MODE   = 16'h6641;
  localparam logic [15:0] IDX_STOP_ONE   = 16'h6650;
  localparam logic [15:0] IDX_OFF_DELAY  = 16'h6651;
  localparam logic [15:0] IDX_ZERO_SPEED = 16'h6653;
  localparam logic [15:0] IDX_ZERO_TIME  = 16'h6654;
  localparam logic [15:0] IDX_DECEL      = 16'h6656;
  localparam logic [15:0] IDX_RAMP_DELAY = 16'h6657;

  // Object subindices
  localparam logic [7:0] SUB_NONE = 8'h00;
  localparam logic [7:0] SUB_LOW  = 8'h01;
  localparam logic [7:0] SUB_HIGH = 8'h02;

  // Command word bit positions (high byte starts at 8)
  localparam int CMD_TORQUE_OFF = 0;
  localparam int CMD_STOP_ONE   = 1;
  localparam int CMD_FAULT_ACK  = 7;
  localparam int CMD_RESET      = 8;

  // Status word bit positions (high byte starts at 8)
  localparam int STS_TORQUE_OFF = 0;
  localparam int STS_WINDOW     = 1;
  localparam int STS_HALT       = 3;
  localparam int STS_FWD        = 5;
  localparam int STS_REV        = 6;
  localparam int STS_FAULT      = 7;
  localparam int STS_RESET      = 8;
  localparam int STS_BRAKE      = 9;
  localparam int STS_SPEED_LIM  = 10;
  localparam int STS_LINK       = 15;

  // Reset values
  localparam logic [15:0] RST_ECHO       = 16'h0000;
  localparam logic [15:0] RST_STATUS     = 16'h0000;
  localparam logic        RST_OFF_MODE   = 1'b0;
  localparam logic        RST_FAULT      = 1'b0;
  localparam logic [15:0] RST_OFF_DELAY  = 16'h03E8;
  localparam logic [31:0] RST_ZERO_SPEED = 32'h0000000A;
  localparam logic [15:0] RST_ZERO_TIME  = 16'h0000;
  localparam logic [31:0] RST_DECEL      = 32'h0000000F;
  localparam logic [15:0] RST_RAMP_DELAY = 16'h000A;

  // Zero-speed threshold range in rpm
  localparam logic [31:0] ZERO_SPEED_MIN = 32'h00000001;
  localparam logic [31:0] ZERO_SPEED_MAX = 32'h00001770;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_STOP1,
    ST_OFF,
    ST_RESET
  } sfcso_state_type;

endpackage

// [sfcso_tmr_if.sv]
/*
  Millisecond timer carrier between the object bank and its timers.
  Assumes tick and run come from logic on the same clock.
*/
`timescale 1ns/10ps
interface sfcso_tmr_if;
  import sfcso_pkg::*;

  logic             tick;
  logic             run;
  logic [TMR_W-1:0] elapsed;

  modport timer (input tick, input run, output elapsed);
  modport user  (output tick, output run, input elapsed);
endinterface

// [sfcso_ms_tick.sv]
/*
  Divider giving a one-cycle pulse once per millisecond.
  Assumes one free-running clock; CYCLES is the tick period in cycles.
*/
`timescale 1ns/10ps
module sfcso_ms_tick #(
  parameter int CYCLES = sfcso_pkg::TICK_CYCLES
) (
  input  logic clk_i,
  input  logic resetn_i,
  output logic tick_o
);
  import sfcso_pkg::*;

  localparam int            CW   = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          next_tick;

  // Wrap counter, pulse on the last count
  always_comb begin
    next_tick = (cnt == LAST);
    next_cnt  = next_tick ? '0 : cnt + 1'b1;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt    <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      tick_o <= next_tick;
    end
  end
endmodule

// [sfcso_ms_timer.sv]
/*
  Saturating millisecond elapsed-time counter.
  Assumes tick is a one-cycle pulse; run low restarts the count.
*/
`timescale 1ns/10ps
module sfcso_ms_timer (
  input logic         clk_i,
  input logic         resetn_i,
  sfcso_tmr_if.timer  tmr
);
  import sfcso_pkg::*;

  localparam logic [TMR_W-1:0] MAX = '1;

  logic [TMR_W-1:0] elapsed;
  logic [TMR_W-1:0] next_elapsed;

  // Restart when idle, count ticks while running
  always_comb begin
    next_elapsed = elapsed;
    if (!tmr.run) begin
      next_elapsed = '0; // [RQ17]
    end else if (tmr.tick && elapsed != MAX) begin
      next_elapsed = elapsed + 1'b1; // [RQ17]
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      elapsed <= '0;
    end else begin
      elapsed <= next_elapsed;
    end
  end

  assign tmr.elapsed = elapsed;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  a_timer_restart: assert property (!tmr.run |=> elapsed == '0) // [RQ17]
    else $error("timer did not restart when idle");
  a_timer_hold: assert property (tmr.run && !tmr.tick |=>
    elapsed == $past(elapsed)) // [RQ17]
    else $error("timer moved without a tick");
  a_timer_step: assert property (tmr.run && tmr.tick && elapsed != MAX
    |=> elapsed == $past(elapsed) + 1'b1) // [RQ17]
    else $error("timer missed a tick");
endmodule

// [sfcso_safety_objects.sv]
/*
  Safety command and status object bank with the torque-off and
  stop-one sequencing it reports on.
  Assumes cyclic command data, motion feedback and service accesses all
  come from logic on clk_i; service access takes one request per cycle.
*/
// Summary of operation
// RQ1: Low echo byte mirrors low command bits
// RQ2: High echo byte mirrors reset, brake, speed bits
// RQ3: Echo bytes track latest command, reset zero
// RQ4: Low status: off, window, halt, motion, fault
// RQ5: High status: reset, brake, speed, link fault
// RQ6: Reset request one; reset state reported one
// RQ7: Fault flag one while faulty, default zero
// RQ8: Torque-off requested by zero, reported by one
// RQ9: Reset mode selects restart acknowledge need
// RQ10: Stop-one requested by zero, reported by one
// RQ11: Delay expiry in stop-one enters torque-off
// RQ12: Zero-speed threshold ends stop-one early
// RQ13: Below-threshold dwell must exceed set time
// RQ14: Ramp check against minimum deceleration limit
// RQ15: Stop-one settings apply only when stopped
// RQ16: Ramp check starts after delay, ramp variant
// RQ17: Millisecond timers restart when condition drops
`timescale 1ns/10ps
module sfcso_safety_objects #(
  parameter int TICK_CYCLES = sfcso_pkg::TICK_CYCLES
) (
  input  logic        clk_i,
  input  logic        resetn_i,
  input  logic        pd_valid_i,
  input  logic [15:0] pd_cmd_i,
  input  logic [15:0] motor_speed_i,
  input  logic [31:0] motor_decel_i,
  input  logic        motor_stopped_i,
  input  logic        ramp_variant_i,
  input  logic        window_out_i,
  input  logic        halt_state_i,
  input  logic        fwd_motion_i,
  input  logic        rev_motion_i,
  input  logic        brake_state_i,
  input  logic [3:0]  speed_lim_state_i,
  input  logic        link_abnormal_i,
  input  logic        ext_fault_i,
  input  logic        sdo_req_i,
  input  logic        sdo_wr_i,
  input  logic [15:0] sdo_index_i,
  input  logic [7:0]  sdo_sub_i,
  input  logic [31:0] sdo_wdata_i,
  output logic        sdo_ack_o,
  output logic        sdo_err_o,
  output logic [31:0] sdo_rdata_o,
  output logic [15:0] cmd_echo_o,
  output logic [15:0] pd_status_o,
  output logic        torque_off_o,
  output logic        stop_one_o,
  output logic        reset_state_o,
  output logic        fault_o
);
  import sfcso_pkg::*;

  // Object address match
  function automatic logic sdo_hit(input logic [15:0] idx,
                                   input logic [7:0]  sub);
    return (sdo_index_i == idx) && (sdo_sub_i == sub);
  endfunction

  sfcso_state_type state;
  sfcso_state_type next_state;
  logic [15:0]     cmd_echo;
  logic [15:0]     next_cmd_echo;
  logic [15:0]     status;
  logic [15:0]     next_status;
  logic            fault;
  logic            next_fault;
  logic            off_mode;
  logic            next_off_mode;
  logic [15:0]     w_delay;
  logic [15:0]     next_w_delay;
  logic [31:0]     w_zero_speed;
  logic [31:0]     next_w_zero_speed;
  logic [15:0]     w_zero_time;
  logic [15:0]     next_w_zero_time;
  logic [31:0]     w_decel;
  logic [31:0]     next_w_decel;
  logic [15:0]     w_ramp_delay;
  logic [15:0]     next_w_ramp_delay;
  logic [15:0]     act_delay;
  logic [15:0]     next_act_delay;
  logic [31:0]     act_zero_speed;
  logic [31:0]     next_act_zero_speed;
  logic [15:0]     act_zero_time;
  logic [15:0]     next_act_zero_time;
  logic [31:0]     act_decel;
  logic [31:0]     next_act_decel;
  logic [15:0]     act_ramp_delay;
  logic [15:0]     next_act_ramp_delay;
  logic            next_sdo_ack;
  logic            next_sdo_err;
  logic [31:0]     next_sdo_rdata;
  logic            tick;
  logic [15:0]     speed_mag;
  logic            below_zero;
  logic            delay_done;
  logic            dwell_done;
  logic            ramp_check;
  logic            ramp_violation;
  logic            off_req;
  logic            stop_req;
  logic            reset_req;
  logic            ack_req;

  sfcso_tmr_if tmr [3] ();

  // Millisecond tick shared by all timers
  sfcso_ms_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .tick_o   (tick)
  );

  // Stop delay, zero-speed dwell and ramp start timers
  for (genvar g = 0; g < 3; g++) begin : g_tmr
    assign tmr[g].tick = tick;
    sfcso_ms_timer u_timer (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .tmr      (tmr[g])
    );
  end

  // Requests are read from the mirrored command word
  assign off_req   = ~cmd_echo[CMD_TORQUE_OFF]; // [RQ8]
  assign stop_req  = ~cmd_echo[CMD_STOP_ONE]; // [RQ10]
  assign reset_req = cmd_echo[CMD_RESET]; // [RQ6]
  assign ack_req   = cmd_echo[CMD_FAULT_ACK];

  // Speed magnitude and stop-one supervision terms
  assign speed_mag  = motor_speed_i[15] ? 16'(-motor_speed_i)
                                        : motor_speed_i;
  assign below_zero = {16'h0000, speed_mag} < act_zero_speed; // [RQ12]
  assign tmr[0].run = (state == ST_STOP1);
  assign tmr[1].run = (state == ST_STOP1) && below_zero; // [RQ13]
  assign tmr[2].run = (state == ST_STOP1) && ramp_variant_i; // [RQ16]
  assign delay_done = tmr[0].elapsed > TMR_W'(act_delay); // [RQ11]
  assign dwell_done = tmr[1].elapsed > TMR_W'(act_zero_time); // [RQ13]
  assign ramp_check = tmr[2].run && !below_zero &&
                      tmr[2].elapsed >= TMR_W'(act_ramp_delay); // [RQ16]
  assign ramp_violation = ramp_check &&
                          (motor_decel_i < act_decel); // [RQ14]

  // Safety state sequencing
  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (fault || off_req) begin
          next_state = ST_OFF; // [RQ8]
        end else if (stop_req) begin
          next_state = ST_STOP1; // [RQ10]
        end
      end
      ST_STOP1: begin
        if (fault || off_req || delay_done || dwell_done) begin
          next_state = ST_OFF; // [RQ11] [RQ12]
        end
      end
      ST_OFF: begin
        if (!fault && !off_req && !stop_req) begin
          if (!off_mode) begin
            next_state = ST_RUN; // [RQ9]
          end else if (reset_req) begin
            next_state = ST_RESET; // [RQ9]
          end
        end
      end
      ST_RESET: begin
        if (fault || off_req || stop_req) begin
          next_state = ST_OFF;
        end else if (!reset_req) begin
          next_state = ST_RUN; // [RQ6]
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
  end

  // Command mirror, fault flag and status word
  always_comb begin
    next_cmd_echo = cmd_echo;
    if (pd_valid_i) begin
      next_cmd_echo = pd_cmd_i; // [RQ1] [RQ2] [RQ3]
    end
    next_fault = fault;
    if (ack_req) begin
      next_fault = 1'b0;
    end
    if (ramp_violation || ext_fault_i) begin
      next_fault = 1'b1; // [RQ7] [RQ14]
    end
    next_status = RST_STATUS;
    next_status[STS_TORQUE_OFF] = (state == ST_OFF); // [RQ4]
    next_status[STS_WINDOW]     = window_out_i; // [RQ4]
    next_status[STS_HALT]       = halt_state_i; // [RQ4]
    next_status[STS_FWD]        = fwd_motion_i; // [RQ4]
    next_status[STS_REV]        = rev_motion_i; // [RQ4]
    next_status[STS_FAULT]      = fault; // [RQ4]
    next_status[STS_RESET]      = (state == ST_RESET); // [RQ5] [RQ6]
    next_status[STS_BRAKE]      = brake_state_i; // [RQ5]
    next_status[STS_SPEED_LIM +: 4] = speed_lim_state_i; // [RQ5]
    next_status[STS_LINK]       = link_abnormal_i; // [RQ5]
  end

  // Service access and settings, active copies load at standstill
  always_comb begin
    next_off_mode     = off_mode;
    next_w_delay      = w_delay;
    next_w_zero_speed = w_zero_speed;
    next_w_zero_time  = w_zero_time;
    next_w_decel      = w_decel;
    next_w_ramp_delay = w_ramp_delay;
    next_sdo_ack      = sdo_req_i;
    next_sdo_err      = 1'b0;
    next_sdo_rdata    = 32'h00000000;
    if (sdo_req_i) begin
      if (sdo_hit(IDX_CMD_ECHO, SUB_LOW)) begin
        next_sdo_rdata = {24'h000000, cmd_echo[7:0]};
        next_sdo_err   = sdo_wr_i;
      end else if (sdo_hit(IDX_CMD_ECHO, SUB_HIGH)) begin
        next_sdo_rdata = {24'h000000, cmd_echo[15:8]};
        next_sdo_err   = sdo_wr_i;
      end else if (sdo_hit(IDX_STATUS, SUB_LOW)) begin
        next_sdo_rdata = {24'h000000, status[7:0]};
        next_sdo_err   = sdo_wr_i;
      end else if (sdo_hit(IDX_STATUS, SUB_HIGH)) begin
        next_sdo_rdata = {24'h000000, status[15:8]};
        next_sdo_err   = sdo_wr_i;
      end else if (sdo_hit(IDX_RESTART, SUB_NONE)) begin
        next_sdo_rdata = {31'h0, state == ST_RESET};
      end else if (sdo_hit(IDX_FAULT, SUB_NONE)) begin
        next_sdo_rdata = {31'h0, fault};
        next_sdo_err   = sdo_wr_i;
      end else if (sdo_hit(IDX_TORQUE_OFF, SUB_NONE)) begin
        next_sdo_rdata = {31'h0, state == ST_OFF};
      end else if (sdo_hit(IDX_STOP_ONE, SUB_LOW)) begin
        next_sdo_rdata = {31'h0, state == ST_STOP1};
      end else if (sdo_hit(IDX_OFF_MODE, SUB_NONE)) begin
        next_sdo_rdata = {31'h0, off_mode};
        if (sdo_wr_i) begin
          next_off_mode = sdo_wdata_i[0]; // [RQ9]
        end
      end else if (sdo_hit(IDX_OFF_DELAY, SUB_LOW)) begin
        next_sdo_rdata = {16'h0000, w_delay};
        if (sdo_wr_i) begin
          next_w_delay = sdo_wdata_i[15:0];
        end
      end else if (sdo_hit(IDX_ZERO_SPEED, SUB_LOW)) begin
        next_sdo_rdata = w_zero_speed;
        if (sdo_wr_i) begin
          if (sdo_wdata_i >= ZERO_SPEED_MIN &&
              sdo_wdata_i <= ZERO_SPEED_MAX) begin
            next_w_zero_speed = sdo_wdata_i; // [RQ12]
          end else begin
            next_sdo_err = 1'b1;
          end
        end
      end else if (sdo_hit(IDX_ZERO_TIME, SUB_LOW)) begin
        next_sdo_rdata = {16'h0000, w_zero_time};
        if (sdo_wr_i) begin
          next_w_zero_time = sdo_wdata_i[15:0];
        end
      end else if (sdo_hit(IDX_DECEL, SUB_LOW)) begin
        next_sdo_rdata = w_decel;
        if (sdo_wr_i) begin
          next_w_decel = sdo_wdata_i;
        end
      end else if (sdo_hit(IDX_RAMP_DELAY, SUB_LOW)) begin
        next_sdo_rdata = {16'h0000, w_ramp_delay};
        if (sdo_wr_i) begin
          next_w_ramp_delay = sdo_wdata_i[15:0];
        end
      end else begin
        next_sdo_err = 1'b1;
      end
    end
    next_act_delay      = act_delay;
    next_act_zero_speed = act_zero_speed;
    next_act_zero_time  = act_zero_time;
    next_act_decel      = act_decel;
    next_act_ramp_delay = act_ramp_delay;
    if (motor_stopped_i) begin
      next_act_delay      = w_delay; // [RQ15]
      next_act_zero_speed = w_zero_speed; // [RQ15]
      next_act_zero_time  = w_zero_time; // [RQ15]
      next_act_decel      = w_decel; // [RQ15]
      next_act_ramp_delay = w_ramp_delay; // [RQ15]
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state          <= ST_OFF;
      cmd_echo       <= RST_ECHO;
      status         <= RST_STATUS;
      fault          <= RST_FAULT;
      off_mode       <= RST_OFF_MODE;
      w_delay        <= RST_OFF_DELAY;
      w_zero_speed   <= RST_ZERO_SPEED;
      w_zero_time    <= RST_ZERO_TIME;
      w_decel        <= RST_DECEL;
      w_ramp_delay   <= RST_RAMP_DELAY;
      act_delay      <= RST_OFF_DELAY;
      act_zero_speed <= RST_ZERO_SPEED;
      act_zero_time  <= RST_ZERO_TIME;
      act_decel      <= RST_DECEL;
      act_ramp_delay <= RST_RAMP_DELAY;
      sdo_ack_o      <= 1'b0;
      sdo_err_o      <= 1'b0;
      sdo_rdata_o    <= 32'h00000000;
    end else begin
      state          <= next_state;
      cmd_echo       <= next_cmd_echo;
      status         <= next_status;
      fault          <= next_fault;
      off_mode       <= next_off_mode;
      w_delay        <= next_w_delay;
      w_zero_speed   <= next_w_zero_speed;
      w_zero_time    <= next_w_zero_time;
      w_decel        <= next_w_decel;
      w_ramp_delay   <= next_w_ramp_delay;
      act_delay      <= next_act_delay;
      act_zero_speed <= next_act_zero_speed;
      act_zero_time  <= next_act_zero_time;
      act_decel      <= next_act_decel;
      act_ramp_delay <= next_act_ramp_delay;
      sdo_ack_o      <= next_sdo_ack;
      sdo_err_o      <= next_sdo_err;
      sdo_rdata_o    <= next_sdo_rdata;
    end
  end

  // State flags straight from the state register, fault flag from the fault register
  assign cmd_echo_o    = cmd_echo;
  assign pd_status_o   = status;
  assign torque_off_o  = (state == ST_OFF); // [RQ8]
  assign stop_one_o    = (state == ST_STOP1); // [RQ10]
  assign reset_state_o = (state == ST_RESET); // [RQ6]
  assign fault_o       = fault; // [RQ7]

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  a_echo_mirror: assert property (pd_valid_i |=>
    cmd_echo_o == $past(pd_cmd_i)) // [RQ3]
    else $error("command echo did not follow the frame");
  a_echo_hold: assert property (!pd_valid_i |=> $stable(cmd_echo_o)) // [RQ3]
    else $error("command echo changed without a frame");
  a_off_request: assert property (state == ST_RUN && off_req |=>
    torque_off_o ##1 pd_status_o[STS_TORQUE_OFF]) // [RQ8]
    else $error("torque-off request not reported");
  a_stop_entry: assert property (state == ST_RUN && !off_req &&
    stop_req && !fault |=> stop_one_o) // [RQ10]
    else $error("stop-one request not taken");
  a_delay_exit: assert property (stop_one_o && delay_done |=>
    torque_off_o) // [RQ11]
    else $error("stop-one delay expiry ignored");
  a_ack_needed: assert property (torque_off_o && off_mode &&
    !reset_req |=> !(state == ST_RUN)) // [RQ9]
    else $error("left torque-off without acknowledge");
  a_reset_report: assert property (state == ST_OFF && off_mode &&
    reset_req && !off_req && !stop_req && !fault |=> reset_state_o
    ##1 pd_status_o[STS_RESET]) // [RQ6]
    else $error("reset state not reported");
  a_fault_sticky: assert property (fault_o && !ack_req |=> fault_o) // [RQ7]
    else $error("fault flag dropped without acknowledge");
  a_param_hold: assert property (!motor_stopped_i |=>
    $stable(act_delay) && $stable(act_decel)) // [RQ15]
    else $error("stop-one setting changed while moving");
endmodule

// [sfcso_host_model.sv]
/*
  Host controller model that sends cyclic safety command words.
  Assumes the bench calls send from its own sequence on clk_i.
*/
`timescale 1ns/10ps
module sfcso_host_model (
  input  logic        clk_i,
  output logic        pd_valid_o,
  output logic [15:0] pd_cmd_o
);
  // Idle state before the first frame
  initial begin
    pd_valid_o = 1'b0;
    pd_cmd_o   = 16'hFFFF;
  end
  // One frame; low torque-off and stop-one bits request, high fault-ack and reset bits request
  task automatic send(input logic [15:0] word);
    @(posedge clk_i);
    pd_valid_o <= 1'b1;
    pd_cmd_o   <= word;
    @(posedge clk_i);
    pd_valid_o <= 1'b0;
    pd_cmd_o   <= ~word;  // Stale word never repeats between frames
  endtask
endmodule

// [sfcso_safety_objects_tb.sv]
/*
  Self-checking bench for the safety object bank.
  Assumes a 4-cycle millisecond tick and the host model on the cyclic side.
*/
`timescale 1ns/10ps
module sfcso_safety_objects_tb;
  import sfcso_pkg::*;
  localparam logic [15:0] REL = 16'hFE7F;
  localparam logic [15:0] DIDX [7] = '{IDX_OFF_DELAY, IDX_ZERO_SPEED,
    IDX_ZERO_TIME, IDX_DECEL, IDX_RAMP_DELAY, IDX_OFF_MODE, IDX_FAULT};
  localparam logic [31:0] DVAL [7] = '{32'h3E8, 32'hA, 32'h0, 32'hF,
    32'hA, 32'h0, 32'h0};
  logic        clk_i, resetn_i, pd_valid_i, motor_stopped_i, ramp_variant_i;
  logic        window_out_i, halt_state_i, fwd_motion_i, rev_motion_i;
  logic        brake_state_i, link_abnormal_i, ext_fault_i, sdo_req_i;
  logic        sdo_wr_i, sdo_ack_o, sdo_err_o, torque_off_o, stop_one_o;
  logic        reset_state_o, fault_o, er;
  logic [3:0]  speed_lim_state_i;
  logic [7:0]  sdo_sub_i;
  logic [15:0] pd_cmd_i, motor_speed_i, sdo_index_i, cmd_echo_o, pd_status_o;
  logic [31:0] motor_decel_i, sdo_wdata_i, sdo_rdata_o, rd;
  int          err_total, n_tests;

  sfcso_host_model host_u (.clk_i, .pd_valid_o(pd_valid_i),
    .pd_cmd_o(pd_cmd_i));
  sfcso_safety_objects #(.TICK_CYCLES(4)) dut_u (.clk_i, .resetn_i,
    .pd_valid_i, .pd_cmd_i, .motor_speed_i, .motor_decel_i, .motor_stopped_i,
    .ramp_variant_i, .window_out_i, .halt_state_i, .fwd_motion_i,
    .rev_motion_i, .brake_state_i, .speed_lim_state_i, .link_abnormal_i,
    .ext_fault_i, .sdo_req_i, .sdo_wr_i, .sdo_index_i, .sdo_sub_i,
    .sdo_wdata_i, .sdo_ack_o, .sdo_err_o, .sdo_rdata_o, .cmd_echo_o,
    .pd_status_o, .torque_off_o, .stop_one_o, .reset_state_o, .fault_o);

  // 40 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // One service access; answer comes one cycle after the request
  task automatic sdo(input logic w, input logic [15:0] ix,
                     input logic [7:0] sb, input logic [31:0] wd);
    @(posedge clk_i);
    sdo_req_i   <= 1'b1;
    sdo_wr_i    <= w;
    sdo_index_i <= ix;
    sdo_sub_i   <= sb;
    sdo_wdata_i <= wd;
    @(posedge clk_i);
    sdo_req_i <= 1'b0;
    #1;
    check(sdo_ack_o, 1'b1);
    rd = sdo_rdata_o;
    er = sdo_err_o;
  endtask
  task automatic test_defaults();
    check(cmd_echo_o, 16'h0000);
    check(torque_off_o, 1'b1);
    for (int i = 0; i < 7; i++) begin
      sdo(1'b0, DIDX[i], (i > 4) ? SUB_NONE : SUB_LOW, 32'h0);
      check(rd, DVAL[i]);
    end
    sdo(1'b0, 16'h6000, SUB_LOW, 32'h0);
    check(er, 1'b1);
    sdo(1'b1, IDX_CMD_ECHO, SUB_LOW, 32'h5);
    check(er, 1'b1);
    sdo(1'b1, IDX_FAULT, SUB_NONE, 32'h1);
    check(er, 1'b1);
    sdo(1'b1, IDX_ZERO_SPEED, SUB_LOW, 32'h1771);
    check(er, 1'b1);
    sdo(1'b1, IDX_ZERO_SPEED, SUB_LOW, 32'h0);
    check(er, 1'b1);
    sdo(1'b1, IDX_ZERO_SPEED, SUB_LOW, 32'h1770);
    check(er, 1'b0);
    sdo(1'b1, IDX_ZERO_SPEED, SUB_LOW, 32'hA);
    $display("defaults done");
  endtask
  task automatic test_echo();
    host_u.send(16'h7F55);
    cyc(1);
    check(cmd_echo_o, 16'h7F55);
    sdo(1'b0, IDX_CMD_ECHO, SUB_LOW, 32'h0);
    check(rd, 32'h55);
    sdo(1'b0, IDX_CMD_ECHO, SUB_HIGH, 32'h0);
    check(rd, 32'h7F);
    host_u.send(REL);
    cyc(2);
    check(torque_off_o, 1'b0);
    $display("echo done");
  endtask
  // Drive the state levels copied into the status word
  task automatic drive_states(input logic [9:0] v);
    @(posedge clk_i);
    window_out_i      <= v[9];
    halt_state_i      <= v[8];
    fwd_motion_i      <= v[7];
    rev_motion_i      <= v[6];
    brake_state_i     <= v[5];
    link_abnormal_i   <= v[4];
    speed_lim_state_i <= v[3:0];
    cyc(3);
  endtask
  task automatic test_status();
    drive_states(10'h295);
    check(pd_status_o, 16'h9422);
    sdo(1'b0, IDX_STATUS, SUB_HIGH, 32'h0);
    check(rd, 32'h94);
    drive_states(10'h16A);
    check(pd_status_o, 16'h2A48);
    sdo(1'b0, IDX_STATUS, SUB_LOW, 32'h0);
    check(rd, 32'h48);
    $display("status done");
  endtask
  task automatic test_restart();
    host_u.send(16'hFE7E);
    cyc(2);
    check(pd_status_o[0], 1'b1);
    sdo(1'b0, IDX_TORQUE_OFF, SUB_NONE, 32'h0);
    check(rd, 32'h1);
    sdo(1'b1, IDX_OFF_MODE, SUB_NONE, 32'h1);
    host_u.send(REL);
    cyc(4);
    check(torque_off_o, 1'b1);
    host_u.send(16'hFF7F);
    cyc(2);
    check({reset_state_o, pd_status_o[8]}, 2'b11);
    sdo(1'b0, IDX_RESTART, SUB_NONE, 32'h0);
    check(rd, 32'h1);
    host_u.send(REL);
    cyc(3);
    check({reset_state_o, torque_off_o}, 2'b00);
    sdo(1'b1, IDX_OFF_MODE, SUB_NONE, 32'h0);
    $display("restart done");
  endtask
  task automatic test_stop_delay();
    sdo(1'b1, IDX_RAMP_DELAY, SUB_LOW, 32'h2);
    motor_stopped_i <= 1'b0;
    motor_decel_i   <= 32'h0;
    sdo(1'b1, IDX_OFF_DELAY, SUB_LOW, 32'h3);
    host_u.send(16'hFE7D);
    cyc(40);
    check(stop_one_o, 1'b1);
    check(fault_o, 1'b0);
    sdo(1'b0, IDX_STOP_ONE, SUB_LOW, 32'h0);
    check(rd, 32'h1);
    motor_stopped_i <= 1'b1;
    for (int i = 0; i < 8 && torque_off_o !== 1'b1; i++) cyc(1);
    check(torque_off_o, 1'b1);
    host_u.send(REL);
    host_u.send(16'hFE7D);
    cyc(8);
    check(stop_one_o, 1'b1);
    for (int i = 0; i < 20 && torque_off_o !== 1'b1; i++) cyc(1);
    check(torque_off_o, 1'b1);
    host_u.send(REL);
    $display("stop delay done");
  endtask
  task automatic test_zero_speed();
    sdo(1'b1, IDX_OFF_DELAY, SUB_LOW, 32'h3E8);
    sdo(1'b1, IDX_ZERO_TIME, SUB_LOW, 32'h5);
    motor_speed_i <= 16'd5;
    host_u.send(16'hFE7D);
    cyc(12);
    check(stop_one_o, 1'b1);
    for (int i = 0; i < 24 && torque_off_o !== 1'b1; i++) cyc(1);
    check(torque_off_o, 1'b1);
    motor_speed_i <= 16'd1000;
    host_u.send(REL);
    $display("zero speed done");
  endtask
  task automatic test_ramp();
    sdo(1'b1, IDX_RAMP_DELAY, SUB_LOW, 32'h2);
    ramp_variant_i <= 1'b1;
    motor_decel_i  <= 32'h0;
    host_u.send(16'hFE7D);
    cyc(3);
    check(fault_o, 1'b0);
    for (int i = 0; i < 20 && fault_o !== 1'b1; i++) cyc(1);
    check(fault_o, 1'b1);
    cyc(2);
    check(pd_status_o[7], 1'b1);
    sdo(1'b0, IDX_FAULT, SUB_NONE, 32'h0);
    check(rd, 32'h1);
    ramp_variant_i <= 1'b0;
    host_u.send(16'hFEFF);
    cyc(3);
    check({fault_o, torque_off_o}, 2'b00);
    host_u.send(REL);
    $display("ramp done");
  endtask
  task automatic test_ext_fault();
    @(posedge clk_i);
    ext_fault_i <= 1'b1;
    @(posedge clk_i);
    ext_fault_i <= 1'b0;
    cyc(2);
    check({fault_o, torque_off_o}, 2'b11);
    host_u.send(16'hFEFF);
    cyc(3);
    check({fault_o, torque_off_o}, 2'b00);
    host_u.send(REL);
    $display("ext fault done");
  endtask
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #(20000 * 25);
    err_total++;
    tally_and_finish();
  end
  // Reset, then scenarios
  initial begin
    {resetn_i, sdo_req_i, sdo_wr_i, ramp_variant_i, ext_fault_i} = 5'h0;
    {window_out_i, halt_state_i, fwd_motion_i, rev_motion_i} = 4'h0;
    {brake_state_i, link_abnormal_i, speed_lim_state_i} = 6'h00;
    {sdo_index_i, sdo_sub_i, sdo_wdata_i} = 56'h0;
    motor_stopped_i = 1'b1;
    motor_speed_i = 16'd1000;
    motor_decel_i = 32'h100;
    err_total = 0;
    n_tests = 0;
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    cyc(1);
    test_defaults();
    test_echo();
    test_status();
    test_restart();
    test_stop_delay();
    test_zero_speed();
    test_ramp();
    test_ext_fault();
    tally_and_finish();
  end
endmodule
